// [ppi_defines.svh]
`ifndef PPI_DEFINES_SVH
`define PPI_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PPI_OFF_A_CTRL 8'h00
`define PPI_OFF_A_ENABLE 8'h04
`define PPI_OFF_A_POL 8'h08
`define PPI_OFF_B_CTRL 8'h0C
`define PPI_OFF_B_ENABLE 8'h10
`define PPI_OFF_B_POL 8'h14
`define PPI_OFF_DRIVE 8'h18
`define PPI_OFF_DATA 8'h1C
`define PPI_OFF_IRQ_STAT 8'h20
`define PPI_OFF_IRQ_MASK 8'h24
// ----------------------------------------
// control register fields, reset values and pin counts
// ----------------------------------------
`define PPI_BIT_MODE 0
`define PPI_BIT_IE 1
`define PPI_BIT_ACK 2
`define PPI_BIT_FLAG 3
`define PPI_CTRL_RESET 8'h00
`define PPI_DRIVE_RESET 8'h00
`define PPI_IRQ_PINS 4
`define PPI_PORT_WIDTH 8
// ----------------------------------------
// bus answer codes
// ----------------------------------------
`define PPI_RESP_OKAY 2'h0
`define PPI_RESP_SLVERR 2'h2
`endif

// [ppi_detect.sv]
`timescale 1ns/1ns
`include "ppi_defines.svh"
module ppi_detect #(
  parameter int N = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N-1:0] pin_sync,
  input wire ppi_pkg::ppi_port_cfg_t cfg,
  output logic [N-1:0] asserted,
  output logic detect
);
  import ppi_pkg::*;
  logic [N-1:0] prev_reg;
  logic [N-1:0] armed_reg;
  logic [N-1:0] armed_next;
  logic [N-1:0] edge_hit;
  logic any_other;
  // ----------------------------------------
  // polarity-normalised level and edges
  // ----------------------------------------
  // asserted level: low when polarity 0, high when 1
  assign asserted = pin_sync ~^ cfg.polarity;
  // edge: deasserted sample then asserted sample next cycle
  assign edge_hit = asserted & ~(prev_reg ~^ cfg.polarity) & armed_reg & cfg.enable;
  // an edge only counts after the pin was seen deasserted
  assign armed_next = (armed_reg | ~asserted) & cfg.enable;
  // edge-only mode blocks latching while another pin is already held
  assign any_other = |(asserted & cfg.enable & ~edge_hit);
  assign detect = cfg.mode ? (|(asserted & cfg.enable)) : ((|edge_hit) & ~any_other);
  // ----------------------------------------
  // sample history
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= '0;
      armed_reg <= '0;
    end else begin
      prev_reg <= pin_sync;
      armed_reg <= armed_next;
    end
  end
  a_edge_needs_arm: assert property (@(posedge aclk) disable iff (!aresetn)
    (|edge_hit) |-> (|$past(armed_next))) else $error("edge without arming");
  a_edge_only_block: assert property (@(posedge aclk) disable iff (!aresetn)
    (!cfg.mode && any_other) |-> !detect) else $error("edge latched while held");
  a_enable_gates: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg.enable == '0) |-> !detect) else $error("detect with no enabled pin");
endmodule : ppi_detect

// [ppi_pin_model.sv]
`timescale 1ns/1ns
// ----------------------------------------
// external source for the port pins
// ----------------------------------------
module ppi_pin_model (
  input wire logic aclk,
  output logic [7:0] port_a_pin,
  output logic [7:0] port_b_pin
);
  logic [3:0] a_lvl = 4'hF;
  logic [3:0] b_lvl = 4'hF;
  logic [3:0] junk = 4'h5;
  // upper pins toggle each cycle: they must never reach the detector
  always @(posedge aclk) junk <= ~junk;
  assign port_a_pin = {junk, a_lvl};
  assign port_b_pin = {~junk, b_lvl};
  // levels move just after an edge, like any synchronous source
  task automatic set_a(input logic [3:0] v);
    a_lvl <= v;
  endtask : set_a
  task automatic set_b(input logic [3:0] v);
    b_lvl <= v;
  endtask : set_b
endmodule : ppi_pin_model

// [ppi_pkg.sv]
package ppi_pkg;
  // axi write address plus data, taken together
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } ppi_wreq_t;
  // per-port configuration as seen by the detector
  typedef struct packed {
    logic mode;
    logic [3:0] enable;
    logic [3:0] polarity;
  } ppi_port_cfg_t;
endpackage : ppi_pkg

// [ppi_top.sv]
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "ppi_defines.svh"
// Contract
// - low four pins of both ports interrupt/wake
// - per-pin enable alone gates pin interrupt
// - mode 0 edges, mode 1 edges and levels
// - polarity picks falling/low or rising/high
// - edges seen by bus-clock sampling
// - edge counts only after deasserted level
// - any detection sets shared port flag bit 3
// - flag and enable bit 1 raise request
// - ack bit 2 clears flag, reads zero
// - writes to flag bit do nothing
// - edge-only: held pin blocks new edge
// - pin asserted state readable in data register
// - drive bits pick low/high, outputs only
module ppi_top #(
  parameter int PINS = `PPI_PORT_WIDTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PINS-1:0] port_a_pin,
  input wire logic [PINS-1:0] port_b_pin,
  input wire logic [PINS-1:0] port_b_dir_out,
  output logic [PINS-1:0] drive_strength_high,
  output logic port_a_irq_req,
  output logic port_b_irq_req,
  output logic wake_req,
  output logic irq
);
  import ppi_pkg::*;
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [PINS-1:0] a_meta_reg, a_sync_reg, b_meta_reg, b_sync_reg;
  logic a_mode_reg, a_ie_reg, a_flag_reg, b_mode_reg, b_ie_reg, b_flag_reg;
  logic [3:0] a_en_reg, a_pol_reg, b_en_reg, b_pol_reg;
  logic [PINS-1:0] drive_reg, drive_out_reg;
  logic [1:0] stat_reg, mask_reg;
  logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  ppi_wreq_t wq_reg;
  logic a_flag_next, b_flag_next;
  logic [1:0] stat_next;
  logic [31:0] rdata_next;
  logic [1:0] rresp_next;
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // two flops before any logic; detector reads only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_meta_reg <= '0;
      a_sync_reg <= '0;
      b_meta_reg <= '0;
      b_sync_reg <= '0;
    end else begin
      a_meta_reg <= port_a_pin;
      a_sync_reg <= a_meta_reg;
      b_meta_reg <= port_b_pin;
      b_sync_reg <= b_meta_reg;
    end
  end
  // ----------------------------------------
  // detectors, one per port, low four pins
  // ----------------------------------------
  ppi_port_cfg_t a_cfg, b_cfg;
  logic [3:0] a_asserted, b_asserted;
  logic a_detect, b_detect;
  assign a_cfg = '{mode: a_mode_reg, enable: a_en_reg, polarity: a_pol_reg};
  assign b_cfg = '{mode: b_mode_reg, enable: b_en_reg, polarity: b_pol_reg};
  ppi_detect #(.N(`PPI_IRQ_PINS)) u_det_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_sync(a_sync_reg[3:0]),
    .cfg(a_cfg),
    .asserted(a_asserted),
    .detect(a_detect)
  );
  ppi_detect #(.N(`PPI_IRQ_PINS)) u_det_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_sync(b_sync_reg[3:0]),
    .cfg(b_cfg),
    .asserted(b_asserted),
    .detect(b_detect)
  );
  // ----------------------------------------
  // write decode
  // ----------------------------------------
  logic wr_fire, rd_fire, wr_lane0;
  logic wr_a_ctrl, wr_a_en, wr_a_pol, wr_b_ctrl, wr_b_en, wr_b_pol;
  logic wr_drive, wr_stat, wr_mask, wr_hit;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_lane0 = wr_fire && wq_reg.strb[0];
  assign wr_a_ctrl = wr_lane0 && wq_reg.addr == `PPI_OFF_A_CTRL;
  assign wr_a_en = wr_lane0 && wq_reg.addr == `PPI_OFF_A_ENABLE;
  assign wr_a_pol = wr_lane0 && wq_reg.addr == `PPI_OFF_A_POL;
  assign wr_b_ctrl = wr_lane0 && wq_reg.addr == `PPI_OFF_B_CTRL;
  assign wr_b_en = wr_lane0 && wq_reg.addr == `PPI_OFF_B_ENABLE;
  assign wr_b_pol = wr_lane0 && wq_reg.addr == `PPI_OFF_B_POL;
  assign wr_drive = wr_lane0 && wq_reg.addr == `PPI_OFF_DRIVE;
  assign wr_stat = wr_lane0 && wq_reg.addr == `PPI_OFF_IRQ_STAT;
  assign wr_mask = wr_lane0 && wq_reg.addr == `PPI_OFF_IRQ_MASK;
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= `PPI_OFF_IRQ_MASK) && (a[1:0] == 2'h0);
  endfunction : mapped
  assign wr_hit = mapped(wq_reg.addr);
  // ----------------------------------------
  // port flags
  // ----------------------------------------
  // detection beats ack in the same cycle, so level mode re-sets at once
  assign a_flag_next = a_detect | (a_flag_reg & ~(wr_a_ctrl & wq_reg.data[`PPI_BIT_ACK]));
  assign b_flag_next = b_detect | (b_flag_reg & ~(wr_b_ctrl & wq_reg.data[`PPI_BIT_ACK]));
  assign port_a_irq_req = a_flag_reg & a_ie_reg;
  assign port_b_irq_req = b_flag_reg & b_ie_reg;
  // any flagged port wakes from wait or deep retained stop
  assign wake_req = a_flag_reg | b_flag_reg;
  // sticky summary status: set wins over write-one-clear
  assign stat_next = {b_flag_next & ~b_flag_reg, a_flag_next & ~a_flag_reg}
    | (stat_reg & ~(wr_stat ? wq_reg.data[1:0] : 2'h0));
  assign irq = |(stat_reg & mask_reg);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_flag_reg <= 1'b0;
      b_flag_reg <= 1'b0;
      stat_reg <= 2'h0;
    end else begin
      a_flag_reg <= a_flag_next;
      b_flag_reg <= b_flag_next;
      stat_reg <= stat_next;
    end
  end
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // flag bit in the written word is ignored: only ack clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_mode_reg <= 1'b0;
      a_ie_reg <= 1'b0;
      b_mode_reg <= 1'b0;
      b_ie_reg <= 1'b0;
      a_en_reg <= 4'h0;
      a_pol_reg <= 4'h0;
      b_en_reg <= 4'h0;
      b_pol_reg <= 4'h0;
      drive_reg <= `PPI_DRIVE_RESET;
      mask_reg <= 2'h0;
    end else begin
      if (wr_a_ctrl) begin
        a_mode_reg <= wq_reg.data[`PPI_BIT_MODE];
        a_ie_reg <= wq_reg.data[`PPI_BIT_IE];
      end
      if (wr_b_ctrl) begin
        b_mode_reg <= wq_reg.data[`PPI_BIT_MODE];
        b_ie_reg <= wq_reg.data[`PPI_BIT_IE];
      end
      if (wr_a_en) a_en_reg <= wq_reg.data[3:0];
      if (wr_a_pol) a_pol_reg <= wq_reg.data[3:0];
      if (wr_b_en) b_en_reg <= wq_reg.data[3:0];
      if (wr_b_pol) b_pol_reg <= wq_reg.data[3:0];
      if (wr_drive) drive_reg <= wq_reg.data[PINS-1:0];
      if (wr_mask) mask_reg <= wq_reg.data[1:0];
    end
  end
  // ----------------------------------------
  // drive strength output
  // ----------------------------------------
  // inputs always show low drive; the bit matters only on outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) drive_out_reg <= '0;
    else drive_out_reg <= drive_reg & port_b_dir_out;
  end
  assign drive_strength_high = drive_out_reg;
  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `PPI_RESP_OKAY;
      wq_reg <= '0;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        wq_reg.addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        wq_reg.data <= s_axi_wdata;
        wq_reg.strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? `PPI_RESP_OKAY : `PPI_RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  assign rd_fire = s_axi_arvalid && !rvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  // ack bit never stored, so it reads back zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    rresp_next = `PPI_RESP_OKAY;
    case (s_axi_araddr)
      `PPI_OFF_A_CTRL: rdata_next[3:0] = {a_flag_reg, 1'b0, a_ie_reg, a_mode_reg};
      `PPI_OFF_A_ENABLE: rdata_next[3:0] = a_en_reg;
      `PPI_OFF_A_POL: rdata_next[3:0] = a_pol_reg;
      `PPI_OFF_B_CTRL: rdata_next[3:0] = {b_flag_reg, 1'b0, b_ie_reg, b_mode_reg};
      `PPI_OFF_B_ENABLE: rdata_next[3:0] = b_en_reg;
      `PPI_OFF_B_POL: rdata_next[3:0] = b_pol_reg;
      `PPI_OFF_DRIVE: rdata_next[PINS-1:0] = drive_reg;
      // pin asserted state per port, A low nibble, B next
      `PPI_OFF_DATA: rdata_next[7:0] = {b_asserted, a_asserted};
      `PPI_OFF_IRQ_STAT: rdata_next[1:0] = stat_reg;
      `PPI_OFF_IRQ_MASK: rdata_next[1:0] = mask_reg;
      default: rresp_next = `PPI_RESP_SLVERR;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `PPI_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_flag_on_detect: assert property (@(posedge aclk) disable iff (!aresetn)
    b_detect |=> b_flag_reg) else $error("port b flag missed detection");
  a_req_needs_ie: assert property (@(posedge aclk) disable iff (!aresetn)
    port_b_irq_req |-> (b_flag_reg && b_ie_reg)) else $error("request without enable");
  a_ack_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_b_ctrl && wq_reg.data[`PPI_BIT_ACK] && !b_detect) |=> !b_flag_reg)
    else $error("ack failed to clear");
  a_flag_write_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_a_ctrl && !wq_reg.data[`PPI_BIT_ACK] && a_flag_reg) |=> a_flag_reg)
    else $error("flag changed by write");
  a_level_reflag: assert property (@(posedge aclk) disable iff (!aresetn)
    (b_mode_reg && |(b_asserted & b_en_reg)) |=> b_flag_reg)
    else $error("level mode flag not reasserted");
  a_drive_input: assert property (@(posedge aclk) disable iff (!aresetn)
    !port_b_dir_out[0] |=> !drive_strength_high[0]) else $error("drive on input");
  a_polarity_map: assert property (@(posedge aclk) disable iff (!aresetn)
    a_asserted[0] == (a_sync_reg[0] == a_pol_reg[0])) else $error("polarity wrong");
  // status bits follow port flag rises and stay until cleared by software
  a_stat_on_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(b_flag_reg) |-> stat_reg[1]) else $error("status missed port b flag");
  a_stat_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (stat_reg[1] && !(wr_stat && wq_reg.data[1])) |=> stat_reg[1])
    else $error("status bit lost");
  a_wake_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(a_flag_reg) |-> wake_req) else $error("no wake");
  c_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire ##[1:4] s_axi_bvalid);
  c_edge_irq: cover property (@(posedge aclk) disable iff (!aresetn) a_detect && !a_mode_reg);
  c_level_ack: cover property (@(posedge aclk) disable iff (!aresetn)
    b_mode_reg && wr_b_ctrl && b_detect);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
endmodule : ppi_top

// [tb_top.sv]
`timescale 1ns/1ns
`include "ppi_defines.svh"
module tb_top;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr, port_a_pin, port_b_pin, port_b_dir_out;
  logic [7:0] drive_strength_high;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic port_a_irq_req, port_b_irq_req, wake_req, irq;
  int n_fail, total_checks;
  // ----------------------------------------
  // design and pin source
  // ----------------------------------------
  ppi_top i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a_pin, .port_b_pin, .port_b_dir_out,
    .drive_strength_high, .port_a_irq_req, .port_b_irq_req, .wake_req, .irq
  );
  ppi_pin_model i_pins (.aclk, .port_a_pin, .port_b_pin);
  // ----------------------------------------
  // bench utilities
  // ----------------------------------------
  task automatic complete_run;
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // a stuck handshake counts as a mismatch and ends the run
  task automatic hang(input string what);
    n_fail++;
    $display("MISMATCH %s expected handshake seen none", what);
    complete_run();
  endtask : hang
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er = `PPI_RESP_OKAY,
                        input logic [3:0] st = 4'hF);
    int n;
    bit aw_ok;
    bit w_ok;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (n = 0; !(aw_ok && w_ok) && n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1 && !aw_ok) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    for (n = 0; s_axi_bvalid !== 1'b1 && n < 40; n++) @(posedge aclk);
    if (s_axi_bvalid !== 1'b1) hang("bvalid");
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask : axi_wr
  // read data is only judged when the access is expected to succeed
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input string what,
                        input logic [1:0] er = `PPI_RESP_OKAY);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) break;
    end
    s_axi_arvalid <= 1'b0;
    for (n = 0; s_axi_rvalid !== 1'b1 && n < 40; n++) @(posedge aclk);
    if (s_axi_rvalid !== 1'b1) hang("rvalid");
    s_axi_rready <= 1'b0;
    if (er == `PPI_RESP_OKAY) chk(what, exp, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask : axi_rd
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("outs", 32'h0, 32'({port_a_irq_req, port_b_irq_req, wake_req, irq}));
    axi_rd(`PPI_OFF_A_CTRL, 32'h0, "a_ctrl");
    axi_rd(`PPI_OFF_B_CTRL, 32'h0, "b_ctrl");
    axi_rd(`PPI_OFF_DRIVE, 32'h0, "drive");
    axi_rd(8'h28, 32'h0, "unmapped", `PPI_RESP_SLVERR);
    axi_wr(8'h28, 32'hFF, `PPI_RESP_SLVERR);
  endtask : t_reset
  // rising polarity on port a, pin 2
  task automatic t_rise_a;
    axi_wr(`PPI_OFF_A_POL, 32'h4);
    i_pins.set_a(4'hB);
    axi_wr(`PPI_OFF_A_ENABLE, 32'h4);
    axi_wr(`PPI_OFF_A_CTRL, 32'h2);
    cyc(4);
    i_pins.set_a(4'hF);
    cyc(6);
    chk("irq_a", 32'h1, 32'(port_a_irq_req));
    axi_rd(`PPI_OFF_DATA, 32'h4, "data");
    axi_wr(`PPI_OFF_A_CTRL, 32'h6);
    cyc(2);
    chk("irq_a", 32'h0, 32'(port_a_irq_req));
  endtask : t_rise_a
  // falling edge on port b, then flag, enable, status and mask handling
  task automatic t_edge_b;
    axi_wr(`PPI_OFF_B_ENABLE, 32'h1);
    axi_wr(`PPI_OFF_B_CTRL, 32'h2);
    cyc(4);
    i_pins.set_b(4'hE);
    cyc(6);
    chk("irq_b", 32'h1, 32'(port_b_irq_req));
    chk("wake", 32'h1, 32'(wake_req));
    axi_rd(`PPI_OFF_B_CTRL, 32'hA, "b_ctrl");
    axi_rd(`PPI_OFF_IRQ_STAT, 32'h3, "stat");
    axi_wr(`PPI_OFF_IRQ_MASK, 32'h2);
    cyc(2);
    chk("irq", 32'h1, 32'(irq));
    axi_wr(`PPI_OFF_IRQ_MASK, 32'h0);
    cyc(2);
    chk("irq", 32'h0, 32'(irq));
    axi_wr(`PPI_OFF_IRQ_STAT, 32'h2);
    axi_rd(`PPI_OFF_IRQ_STAT, 32'h1, "stat");
    axi_wr(`PPI_OFF_IRQ_STAT, 32'h1);
    axi_rd(`PPI_OFF_IRQ_STAT, 32'h0, "stat");
    axi_wr(`PPI_OFF_B_CTRL, 32'h0);
    cyc(2);
    chk("irq_b", 32'h0, 32'(port_b_irq_req));
    axi_rd(`PPI_OFF_B_CTRL, 32'h8, "b_ctrl");
    axi_wr(`PPI_OFF_B_CTRL, 32'h6);
    cyc(4);
    axi_rd(`PPI_OFF_B_CTRL, 32'h2, "b_ctrl");
    chk("irq_b", 32'h0, 32'(port_b_irq_req));
    i_pins.set_b(4'hF);
  endtask : t_edge_b
  // level mode re-flags while the pin stays asserted
  task automatic t_level_b;
    axi_wr(`PPI_OFF_B_CTRL, 32'h3);
    i_pins.set_b(4'hE);
    cyc(6);
    axi_wr(`PPI_OFF_B_CTRL, 32'h7);
    axi_rd(`PPI_OFF_B_CTRL, 32'hB, "b_ctrl");
    i_pins.set_b(4'hF);
    cyc(6);
    axi_wr(`PPI_OFF_B_CTRL, 32'h7);
    axi_rd(`PPI_OFF_B_CTRL, 32'h3, "b_ctrl");
  endtask : t_level_b
  // held pin blocks, disabled pin ignored, enabling while low needs re-arming
  task automatic t_block_b;
    axi_wr(`PPI_OFF_B_CTRL, 32'h2);
    axi_wr(`PPI_OFF_B_ENABLE, 32'h3);
    cyc(4);
    i_pins.set_b(4'hD);
    cyc(6);
    chk("irq_b", 32'h1, 32'(port_b_irq_req));
    axi_wr(`PPI_OFF_B_CTRL, 32'h6);
    i_pins.set_b(4'hC);
    cyc(6);
    chk("irq_b", 32'h0, 32'(port_b_irq_req));
    i_pins.set_b(4'hF);
    cyc(6);
    i_pins.set_b(4'h7);
    cyc(6);
    chk("irq_b", 32'h0, 32'(port_b_irq_req));
    i_pins.set_b(4'hB);
    axi_wr(`PPI_OFF_B_ENABLE, 32'h4);
    cyc(6);
    chk("irq_b", 32'h0, 32'(port_b_irq_req));
    i_pins.set_b(4'hF);
    cyc(4);
    i_pins.set_b(4'hB);
    cyc(6);
    chk("irq_b", 32'h1, 32'(port_b_irq_req));
    axi_wr(`PPI_OFF_B_CTRL, 32'h6);
  endtask : t_block_b
  // drive strength only reaches pins set as outputs
  task automatic t_drive;
    axi_wr(`PPI_OFF_DRIVE, 32'hA5);
    port_b_dir_out <= 8'h0F;
    cyc(3);
    chk("drive", 32'h05, 32'(drive_strength_high));
    port_b_dir_out <= 8'hF0;
    cyc(3);
    chk("drive", 32'hA0, 32'(drive_strength_high));
    axi_rd(`PPI_OFF_DRIVE, 32'hA5, "drive");
  endtask : t_drive
  // lane 0 strobe off, port a level mode, then a reset in mid-run
  task automatic t_misc;
    axi_wr(`PPI_OFF_A_CTRL, 32'h3, `PPI_RESP_OKAY, 4'hE);
    axi_rd(`PPI_OFF_A_CTRL, 32'h2, "a_ctrl");
    axi_wr(`PPI_OFF_A_CTRL, 32'h3);
    cyc(4);
    axi_rd(`PPI_OFF_A_CTRL, 32'hB, "a_ctrl");
    chk("irq_a", 32'h1, 32'(port_a_irq_req));
    aresetn <= 1'b0;
    cyc(3);
    aresetn <= 1'b1;
    chk("outs", 32'h0, 32'({drive_strength_high, port_a_irq_req, port_b_irq_req, wake_req, irq}));
    axi_rd(`PPI_OFF_A_CTRL, 32'h0, "a_ctrl");
    axi_rd(`PPI_OFF_DRIVE, 32'h0, "drive");
  endtask : t_misc
  // ----------------------------------------
  // clock, reset and main sequence
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    port_b_dir_out = 8'h00;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_rise_a();
    t_edge_b();
    t_level_b();
    t_block_b();
    t_drive();
    t_misc();
    complete_run();
  end
endmodule : tb_top
